/* File: src/upeer_regs.sv */
`timescale 1ns/100ps
// Operation
// R1: offset 0x18 has no storage, reads the scratch byte, and written ones clear scratch bits.
// R2: the 8-bit power-control register at 0x3D is read/write and resets to all zeros.
// R3: offset 0x3E reads power-control, and written ones set bits while zeros do nothing.
// R4: offset 0x3F reads power-control, and written ones clear bits while zeros do nothing.
// R5: with bit 6 set, every change of supply-good raises an event command.
// R6: with bit 5 set, every change of id-pin-open raises an event command.
// R7: with bit 4 set, any change of any of the three id-resistor indications raises an event.
// R8: with bit 3 set, a falling bvalid raises an event command with alt_int high.
// R9: with bit 2 set, a rising bvalid raises an event command with alt_int high.
// R10: with bit 0 set, every change of the stress indication raises an event command.
// R11: the link never writes a one to bits 7 or 1 of the power-control register.
// R12: the scratch clear alias shows all eight bits, reset value zero.
// R13: the scratch byte at 0x16 is free read/write storage with no effect on function.
// R14: with an enable bit at zero, changes of its indication raise no event command.
module upeer_regs (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic SUPPLY_GOOD,
  input wire logic IDPIN_OPEN,
  input wire logic IDPIN_RESISTOR_A,
  input wire logic IDPIN_RESISTOR_B,
  input wire logic IDPIN_RESISTOR_C,
  input wire logic BVALID,
  input wire logic STRESS_DETECT,
  output logic RXCMD_REQ,
  output logic RXCMD_ALT_INT,
  input wire logic RXCMD_ACK,
  output logic [7:0] STATUS_SNAPSHOT
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] scratch_r;
  logic [7:0] pwr_en_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // each group is one stored byte seen at three offsets: plain, set alias, clear alias
  function automatic logic scratch_hit(input logic [5:0] addr);
    return (addr == upeer_pkg::SCRATCH_OFF) ||
      (addr == upeer_pkg::SCRATCH_SET_OFF) ||
      (addr == upeer_pkg::SCRATCH_CLR_OFF);
  endfunction

  function automatic logic pwr_hit(input logic [5:0] addr);
    return (addr == upeer_pkg::PWR_EN_OFF) ||
      (addr == upeer_pkg::PWR_EN_SET_OFF) ||
      (addr == upeer_pkg::PWR_EN_CLR_OFF);
  endfunction

  // ----------------------------------------
  // scratch byte
  // ----------------------------------------
  // scratch byte feeds only the read path, no other logic
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      scratch_r <= upeer_pkg::SCRATCH_RST; // R12
    else if (REG_WR && scratch_hit(REG_ADDR))
    begin
      unique case (REG_ADDR)
        upeer_pkg::SCRATCH_OFF: scratch_r <= REG_WDATA; // R13
        upeer_pkg::SCRATCH_SET_OFF: scratch_r <= scratch_r | REG_WDATA; // R13
        upeer_pkg::SCRATCH_CLR_OFF: scratch_r <= scratch_r & ~REG_WDATA; // R1
        default: scratch_r <= scratch_r;
      endcase
    end
  end

  // ----------------------------------------
  // power-control register
  // ----------------------------------------
  // reserved bits 7 and 1 are stored as written; the link keeps them zero
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      pwr_en_r <= upeer_pkg::PWR_EN_RST; // R2
    else if (REG_WR && pwr_hit(REG_ADDR))
    begin
      unique case (REG_ADDR)
        upeer_pkg::PWR_EN_OFF: pwr_en_r <= REG_WDATA; // R2
        upeer_pkg::PWR_EN_SET_OFF: pwr_en_r <= pwr_en_r | REG_WDATA; // R3
        upeer_pkg::PWR_EN_CLR_OFF: pwr_en_r <= pwr_en_r & ~REG_WDATA; // R4
        default: pwr_en_r <= pwr_en_r;
      endcase
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped offsets read as zero so a stray read never looks like a live enable
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (scratch_hit(REG_ADDR))
      rdata_nxt = scratch_r; // R1 R12 R13
    else if (pwr_hit(REG_ADDR))
      rdata_nxt = pwr_en_r; // R2 R3 R4
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      REG_RDATA <= 8'h00;
    else
      REG_RDATA <= rdata_nxt;
  end

  // ----------------------------------------
  // indication synchronisers
  // ----------------------------------------
  logic [upeer_pkg::NUM_SRC-1:0] src_q;
  logic [upeer_pkg::NUM_SRC-1:0] src_rise;
  logic [upeer_pkg::NUM_SRC-1:0] src_fall;

  upeer_sync #(.W(upeer_pkg::NUM_SRC)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({STRESS_DETECT, BVALID, IDPIN_RESISTOR_C, IDPIN_RESISTOR_B,
        IDPIN_RESISTOR_A, IDPIN_OPEN, SUPPLY_GOOD}),
    .q(src_q),
    .rise(src_rise),
    .fall(src_fall)
  );

  // ----------------------------------------
  // event qualification
  // ----------------------------------------
  logic [upeer_pkg::NUM_SRC-1:0] chg;
  logic ev_plain;
  logic ev_alt;
  assign chg = src_rise | src_fall;

  always_comb
  begin
    ev_plain = 1'b0;
    ev_alt = 1'b0;
    if (pwr_en_r[upeer_pkg::SUPPLY_EN_BIT] && chg[0])
      ev_plain = 1'b1; // R5 R14
    if (pwr_en_r[upeer_pkg::IDOPEN_EN_BIT] && chg[1])
      ev_plain = 1'b1; // R6 R14
    if (pwr_en_r[upeer_pkg::IDRES_EN_BIT] && (|chg[4:2]))
      ev_plain = 1'b1; // R7 R14
    if (pwr_en_r[upeer_pkg::BVALID_FALL_BIT] && src_fall[5])
      ev_alt = 1'b1; // R8 R14
    if (pwr_en_r[upeer_pkg::BVALID_RISE_BIT] && src_rise[5])
      ev_alt = 1'b1; // R9 R14
    if (pwr_en_r[upeer_pkg::STRESS_EN_BIT] && chg[6])
      ev_plain = 1'b1; // R10 R14
  end

  // ----------------------------------------
  // event command request to the framer
  // ----------------------------------------
  // events arriving while a request is pending merge into it, set beats ack
  upeer_pkg::upeer_req_t req_state_r;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      req_state_r <= upeer_pkg::UPEER_REQ_IDLE;
    else
    begin
      unique case (req_state_r)
        upeer_pkg::UPEER_REQ_IDLE:
        begin
          if (ev_plain || ev_alt)
            req_state_r <= upeer_pkg::UPEER_REQ_WAIT; // R5 R6 R7 R8 R9 R10
        end
        upeer_pkg::UPEER_REQ_WAIT:
        begin
          // a new event in the ack cycle keeps the request up
          if (RXCMD_ACK && !(ev_plain || ev_alt))
            req_state_r <= upeer_pkg::UPEER_REQ_IDLE;
        end
        default: req_state_r <= upeer_pkg::UPEER_REQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // alt_int flag
  // ----------------------------------------
  // a merged command carries alt_int if any of its events was a bvalid edge
  logic alt_r;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      alt_r <= 1'b0;
    else if (ev_alt)
      alt_r <= 1'b1; // R8 R9
    else if (RXCMD_ACK)
      alt_r <= 1'b0;
  end

  // ----------------------------------------
  // status snapshot
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      STATUS_SNAPSHOT <= 8'h00;
    else
      STATUS_SNAPSHOT <= {1'b0, src_q};
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RXCMD_REQ = (req_state_r == upeer_pkg::UPEER_REQ_WAIT);
  assign RXCMD_ALT_INT = alt_r;
endmodule

/* File: src/upeer_pkg.sv */
package upeer_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [5:0] SCRATCH_OFF = 6'h16;
  localparam logic [5:0] SCRATCH_SET_OFF = 6'h17;
  localparam logic [5:0] SCRATCH_CLR_OFF = 6'h18;
  localparam logic [5:0] PWR_EN_OFF = 6'h3d;
  localparam logic [5:0] PWR_EN_SET_OFF = 6'h3e;
  localparam logic [5:0] PWR_EN_CLR_OFF = 6'h3f;
  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] PWR_EN_RST = 8'h00;
  localparam int STRESS_EN_BIT = 0;
  localparam int BVALID_RISE_BIT = 2;
  localparam int BVALID_FALL_BIT = 3;
  localparam int IDRES_EN_BIT = 4;
  localparam int IDOPEN_EN_BIT = 5;
  localparam int SUPPLY_EN_BIT = 6;
  // ----------------------------------------
  // event sources: supply, idopen, idres a/b/c, bvalid, stress
  // ----------------------------------------
  localparam int NUM_SRC = 7;
  typedef enum logic [1:0] {
    UPEER_REQ_IDLE = 2'b00,
    UPEER_REQ_WAIT = 2'b01
  } upeer_req_t;
endpackage

/* File: src/upeer_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser plus edge detect on the second flop's output
module upeer_sync #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign q = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule

/* File: bench/upeer_regs_asserts.sv */
`timescale 1ns/100ps
module upeer_regs_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic RXCMD_REQ,
  input wire logic RXCMD_ALT_INT,
  input wire logic RXCMD_ACK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_wr(a); REG_WR && REG_ADDR == a ##1 !REG_WR && REG_ADDR == a; endsequence
  property p_rst; $rose(RST_N) |-> REG_RDATA == 8'h00 && !RXCMD_REQ; endproperty
  a_rst: assert property (p_rst) else $error("reset out");
  property p_pwr; s_wr(6'h3d) |=> REG_RDATA == $past(REG_WDATA, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("pwr rd");
  property p_set; s_wr(6'h3e) |=> (REG_RDATA & $past(REG_WDATA, 2)) == $past(REG_WDATA, 2);
  endproperty
  a_set: assert property (p_set) else $error("set alias");
  property p_clr; s_wr(6'h3f) |=> (REG_RDATA & $past(REG_WDATA, 2)) == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clr alias");
  property p_scr; s_wr(6'h16) |=> REG_RDATA == $past(REG_WDATA, 2); endproperty
  a_scr: assert property (p_scr) else $error("scratch");
  property p_sclr; s_wr(6'h18) |=> (REG_RDATA & $past(REG_WDATA, 2)) == 8'h00; endproperty
  a_sclr: assert property (p_sclr) else $error("scratch clr");
  property p_alt; RXCMD_ALT_INT |-> RXCMD_REQ; endproperty
  a_alt: assert property (p_alt) else $error("alt no req");
  property p_hold; RXCMD_REQ && !RXCMD_ACK |=> RXCMD_REQ; endproperty
  a_hold: assert property (p_hold) else $error("req lost");
  cover property (RXCMD_REQ && RXCMD_ALT_INT);
  cover property (RXCMD_REQ && RXCMD_ACK);
  cover property (s_wr(6'h3f));
endmodule
bind upeer_regs upeer_regs_chk i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .RXCMD_REQ(RXCMD_REQ), .RXCMD_ALT_INT(RXCMD_ALT_INT), .RXCMD_ACK(RXCMD_ACK));

/* File: bench/upeer_link_model.sv */
`timescale 1ns/100ps
// framer side: acks a pending command after dly idle cycles
module upeer_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] dly,
  input wire logic req,
  output logic ack
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ack, cnt_r} <= 5'h00;
    else
      {ack, cnt_r} <= (req && !ack) ? ((cnt_r >= dly) ? 5'h10 : {1'b0, cnt_r + 4'h1}) : 5'h00;
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_s = 1'b0;
  logic [5:0] ad = 6'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat;
  logic [6:0] src = 7'h00;
  logic req, alt, ack;
  logic [7:0] snap;
  logic [3:0] dly = 4'h0;
  logic [5:0] offs[6] = '{6'h16, 6'h17, 6'h18, 6'h3d, 6'h3e, 6'h3f};
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  upeer_regs i_dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_WR(wr_s), .REG_ADDR(ad), .REG_WDATA(wd),
    .REG_RDATA(rdat), .SUPPLY_GOOD(src[0]), .IDPIN_OPEN(src[1]), .IDPIN_RESISTOR_A(src[2]),
    .IDPIN_RESISTOR_B(src[3]), .IDPIN_RESISTOR_C(src[4]), .BVALID(src[5]),
    .STRESS_DETECT(src[6]), .RXCMD_REQ(req), .RXCMD_ALT_INT(alt), .RXCMD_ACK(ack),
    .STATUS_SNAPSHOT(snap));
  upeer_link_model i_link (.clk(clk), .rst_n(rst_n), .dly(dly), .req(req), .ack(ack));
  initial forever #5 clk = ~clk;
  always @(posedge clk)
    if (++cyc > 3000)
    begin
      err_count++;
      end_of_test();
    end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(negedge clk);
    {wr_s, ad, wd} = {1'b1, a, d};
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] exp);
    ad = a;
    repeat (2) @(negedge clk);
    chk("rdata", exp, rdat);
  endtask
  // toggle one source; a missing or spurious command shows in the wait
  task automatic ev(int i, logic er, logic ea);
    src[i] = ~src[i];
    for (int k = 0; k < 8 && req !== 1'b1; k++) @(negedge clk);
    chk("req", {7'h00, er}, {7'h00, req});
    if (er) chk("alt", {7'h00, ea}, {7'h00, alt});
    for (int k = 0; k < 20 && req !== 1'b0; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("snap", {1'b0, src}, snap);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    foreach (offs[j]) rd(offs[j], 8'h00);
    wr(6'h20, 8'hff);
    rd(6'h20, 8'h00);
    wr(6'h16, 8'ha5);
    rd(6'h16, 8'ha5);
    rd(6'h18, 8'ha5);
    wr(6'h18, 8'h81);
    rd(6'h18, 8'h24);
    rd(6'h16, 8'h24);
    wr(6'h17, 8'h42);
    rd(6'h17, 8'h66);
    wr(6'h3d, 8'h7d);
    rd(6'h3d, 8'h7d);
    for (int i = 0; i < 7; i++)
    begin
      dly = 4'(i);
      ev(i, 1'b1, i == 5);
      ev(i, 1'b1, i == 5);
    end
    wr(6'h3f, 8'h08);
    rd(6'h3e, 8'h75);
    ev(5, 1'b1, 1'b1);
    ev(5, 1'b0, 1'b0);
    wr(6'h3e, 8'h08);
    wr(6'h3f, 8'h04);
    rd(6'h3f, 8'h79);
    ev(5, 1'b0, 1'b0);
    ev(5, 1'b1, 1'b1);
    wr(6'h3f, 8'h7d);
    for (int i = 0; i < 7; i++) ev(i, 1'b0, 1'b0);
    end_of_test();
  end
endmodule
